/* verilog/bem_pkg.sv */
// Shared constants and types of the bit-error measurement core
package bem_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] DECADE_LAST = 4'h9;
   localparam int SES_SCALE = 1000;
   localparam int DM_SCALE = 1000000;
   localparam logic [3:0] RUN_LAST = 4'h9;
   localparam logic [5:0] MIN_LAST = 6'h3b;
   localparam logic [31:0] NAN_WORD = 32'h7e95_1b02;
   // Arbitrary code meaning no text line is pending
   localparam logic [31:0] NO_TEXT_WORD = 32'hffff_fffe;

   localparam int ADDR_W = 10;
   localparam logic [9:0] OFF_CTRL = 10'h000;
   localparam logic [9:0] OFF_SBIT_POS = 10'h004;
   localparam logic [9:0] OFF_BLK_START = 10'h008;
   localparam logic [9:0] OFF_BLK_LEN = 10'h00c;
   localparam logic [9:0] OFF_GATE_LIMIT = 10'h010;
   localparam logic [9:0] OFF_LOG = 10'h014;
   localparam logic [9:0] OFF_FREQ = 10'h018;
   localparam logic [9:0] OFF_ELAPSED = 10'h01c;
   localparam logic [9:0] OFF_CNT_BASE = 10'h100;
   localparam logic [9:0] OFF_DELTA_BASE = 10'h180;
   localparam logic [9:0] OFF_RATIO_BASE = 10'h1c0;

   localparam int CTRL_BLOCK = 0;
   localparam int CTRL_CAPTURE = 1;
   localparam int CTRL_MAN_LO = 2;
   localparam int CTRL_MAN_HI = 3;
   localparam int CTRL_REP = 4;
   localparam int CTRL_PREV = 5;
   localparam int CTRL_PREV_OK = 6;
   localparam int CTRL_GATE = 7;

   localparam int CNT_ERR = 0;
   localparam int CNT_BITS = 1;
   localparam int CNT_ZASO = 2;
   localparam int CNT_OASZ = 3;
   localparam int CNT_SB_ERR = 4;
   localparam int CNT_SB_BITS = 5;
   localparam int CNT_ES_BASE = 6;
   localparam int CNT_EF_BASE = 10;
   localparam int CNT_PWR = 14;
   localparam int CNT_SYNC = 15;
   localparam int CNT_SECS = 16;
   localparam int CNT_AVAIL = 17;
   localparam int CNT_UNAV = 18;
   localparam int CNT_SES = 19;
   localparam int CNT_DM = 20;
   localparam int CNT_MIN = 21;
   localparam int CNT_CLK = 22;
   localparam int NUM_CNT = 23;
   localparam int NUM_DELTA = 4;
   localparam int NUM_RATIO = 11;
   localparam logic [3:0] RATIO_LAST = 4'ha;

   typedef enum logic [1:0] {MAN_TIME, MAN_ERRORS, MAN_BITS} bem_manner_type;
   typedef enum logic {DIV_LOAD, DIV_RUN} bem_div_state_type;

   typedef struct packed {
      logic [9:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bem_bus_req_type;

   typedef struct packed {
      logic valid;
      logic rx;
      logic ref_bit;
      logic [31:0] pos;
   } bem_sample_type;
endpackage : bem_pkg

/* verilog/bem_counters.sv */
// Error measurement, error location and result counters of the bit-error detector
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module bem_counters
   import bem_pkg::*;
#(
   parameter int MS_CYC = MS_CYCLES
) (
   input wire logic mclk, // Recovered input clock
   input wire logic sys_rst, // Asynchronous reset, active high
   input wire bem_bus_req_type bus, // Register access request
   output logic [31:0] rdata, // Read data, cycle after read strobe
   input wire bem_sample_type smp, // Received and reference bit with position
   input wire logic [31:0] pattern_len, // Pattern length in bits
   input wire logic prbs_sel, // Pure PRBS pattern selected
   input wire logic sync_lost, // Pattern not synchronised
   input wire logic pwr_fail_pin, // Power loss indication pin
   input wire logic pwr_meas_ok, // Power loss measurement possible
   input wire logic gate_on, // Gating requested
   input wire logic log_valid, // Log line offered
   input wire logic [31:0] log_line, // Log line word
   output logic log_ready, // Log line holder is empty
   output logic gate_done, // Gating limit reached, one cycle
   output logic gate_active, // Gating period running
   output logic capture_busy // Error capture armed
);
   logic block_on_q, rep_q, prev_sel_q, capture_q, gate_on_q, gate_act_q, gate_done_q;
   logic prev_ok_q, ran_q, log_pend_q, unav_q, cnt_en;
   bem_manner_type manner_q;
   logic [31:0] sbit_pos_q, blk_start_q, blk_len_q, limit_q, log_q, rdata_q;
   logic [31:0] cnt_q [NUM_CNT];
   logic [31:0] prev_q [NUM_CNT];
   logic [31:0] win_q [NUM_DELTA];
   logic [31:0] delta_q [NUM_DELTA];
   logic [31:0] ratio_q [NUM_RATIO];
   logic [NUM_RATIO-1:0] rnan_q;
   logic [NUM_CNT-1:0] inc;
   logic [NUM_DELTA-1:0] dinc;
   logic [13:0] ms_q;
   logic [3:0] dec_q [3];
   logic [3:0] tick;
   logic [3:0] flag_q;
   logic pf_s1, pf_s2, pf_s3, pf_q, pwr_sec_q, sync_sec_q;
   logic [31:0] freq_cnt_q, freq_q, sec_err_q, sec_bits_q, min_err_q, min_bits_q;
   logic [3:0] ses_run_q, ok_run_q;
   logic [5:0] min_cnt_q;

   wire gate_start = gate_on & ~gate_on_q;
   wire blk_eff = block_on_q & ~prbs_sel;
   wire [31:0] blk_off = (smp.pos >= blk_start_q) ? smp.pos - blk_start_q
                                                  : smp.pos + pattern_len - blk_start_q;
   wire counted = smp.valid & (~blk_eff | (blk_off < blk_len_q));
   wire err_now = counted & (smp.rx ^ smp.ref_bit);
   wire bit_hit = counted & ~prbs_sel & (smp.pos == sbit_pos_q);
   wire cap_fire = capture_q & ~prbs_sel & smp.valid & (smp.rx ^ smp.ref_bit);

   wire wr_ctrl = bus.wr & (bus.addr == OFF_CTRL);
   wire wr_sbit = bus.wr & (bus.addr == OFF_SBIT_POS);
   wire wr_start = bus.wr & (bus.addr == OFF_BLK_START);
   wire wr_len = bus.wr & (bus.addr == OFF_BLK_LEN);
   wire wr_limit = bus.wr & (bus.addr == OFF_GATE_LIMIT);
   wire rd_log = bus.rd & (bus.addr == OFF_LOG);

   // Pin synchroniser, a change counts once stages two and three agree
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         {pf_s1, pf_s2, pf_s3, pf_q} <= 4'h0;
      end else begin
         pf_s1 <= pwr_fail_pin;
         pf_s2 <= pf_s1;
         pf_s3 <= pf_s2;
         if (pf_s2 == pf_s3) pf_q <= pf_s3;
      end
   end

   wire ms_last = (ms_q == 14'(MS_CYC - 1));
   assign tick[0] = ms_last;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) ms_q <= 14'h0;
      else if (gate_start | ms_last) ms_q <= 14'h0;
      else ms_q <= ms_q + 14'h1;
   end

   genvar k;
   generate
      for (k = 0; k < 3; k++) begin : g_decade
         assign tick[k+1] = tick[k] & (dec_q[k] == DECADE_LAST);
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) dec_q[k] <= 4'h0;
            else if (gate_start | tick[k+1]) dec_q[k] <= 4'h0;
            else if (tick[k]) dec_q[k] <= dec_q[k] + 4'h1;
         end
      end
      for (k = 0; k < 4; k++) begin : g_interval
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) flag_q[k] <= 1'b0;
            else if (gate_start) flag_q[k] <= 1'b0;
            else flag_q[k] <= ~tick[k] & (flag_q[k] | err_now);
         end
         assign inc[CNT_ES_BASE+k] = tick[k] & (flag_q[k] | err_now);
         assign inc[CNT_EF_BASE+k] = tick[k] & ~(flag_q[k] | err_now);
      end
      // Decisecond windows run regardless of gating
      for (k = 0; k < NUM_DELTA; k++) begin : g_delta
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               win_q[k] <= 32'h0;
               delta_q[k] <= 32'h0;
            end else if (tick[2]) begin
               delta_q[k] <= win_q[k];
               win_q[k] <= {31'h0, dinc[k]};
            end else if (gate_start) begin
               // Window restarts with the timebase so it never spans more than a decisecond
               win_q[k] <= {31'h0, dinc[k]};
            end else if (dinc[k]) begin
               win_q[k] <= win_q[k] + 32'h1;
            end
         end
      end
      // Clear on start, keep previous period
      for (k = 0; k < NUM_CNT; k++) begin : g_cnt
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               cnt_q[k] <= 32'h0;
               prev_q[k] <= 32'h0;
            end else if (gate_start) begin
               prev_q[k] <= cnt_q[k];
               cnt_q[k] <= 32'h0;
            end else if (cnt_en & inc[k]) begin
               cnt_q[k] <= cnt_q[k] + 32'h1;
            end
         end
      end
   endgenerate

   assign dinc = {bit_hit, bit_hit & err_now, counted, err_now};
   assign inc[CNT_ERR] = err_now;
   assign inc[CNT_BITS] = counted;
   assign inc[CNT_ZASO] = err_now & ~smp.ref_bit;
   assign inc[CNT_OASZ] = err_now & smp.ref_bit;
   assign inc[CNT_SB_ERR] = bit_hit & err_now;
   assign inc[CNT_SB_BITS] = bit_hit;
   assign inc[CNT_PWR] = tick[3] & (pwr_sec_q | pf_q);
   assign inc[CNT_SYNC] = tick[3] & (sync_sec_q | sync_lost);
   assign inc[CNT_SECS] = tick[3];
   assign inc[CNT_CLK] = smp.valid;

   // Second classification: unavailable from the tenth consecutive severely errored second
   wire ses_now = ({10'h0, sec_err_q} * 42'(SES_SCALE)) > {10'h0, sec_bits_q};
   wire sec_unav = unav_q ? ~(~ses_now & (ok_run_q == RUN_LAST))
                          : (ses_now & (ses_run_q == RUN_LAST));
   wire min_step = tick[3] & ~sec_unav & ~ses_now;
   wire min_end = min_step & (min_cnt_q == MIN_LAST);
   wire dm_now = (64'(min_err_q + sec_err_q) * 64'(DM_SCALE)) > 64'(min_bits_q + sec_bits_q);
   assign inc[CNT_AVAIL] = tick[3] & ~sec_unav;
   assign inc[CNT_UNAV] = tick[3] & sec_unav;
   assign inc[CNT_SES] = tick[3] & ~sec_unav & ses_now;
   assign inc[CNT_MIN] = min_end;
   assign inc[CNT_DM] = min_end & dm_now;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         {pwr_sec_q, sync_sec_q, unav_q} <= 3'h0;
         {sec_err_q, sec_bits_q, freq_cnt_q, freq_q} <= 128'h0;
         {min_err_q, min_bits_q} <= 64'h0;
         {ses_run_q, ok_run_q} <= 8'h0;
         min_cnt_q <= 6'h0;
      end else begin
         // Second accumulators except the frequency count restart with the timebase so no earlier time leaks in
         pwr_sec_q <= ~(tick[3] | gate_start) & (pwr_sec_q | pf_q);
         sync_sec_q <= ~(tick[3] | gate_start) & (sync_sec_q | sync_lost);
         freq_cnt_q <= tick[3] ? {31'h0, smp.valid} : freq_cnt_q + {31'h0, smp.valid};
         if (tick[3]) freq_q <= freq_cnt_q;
         sec_err_q <= (tick[3] | gate_start) ? {31'h0, err_now} : sec_err_q + {31'h0, err_now};
         sec_bits_q <= (tick[3] | gate_start) ? {31'h0, counted} : sec_bits_q + {31'h0, counted};
         if (gate_start) begin
            {ses_run_q, ok_run_q} <= 8'h0;
            unav_q <= 1'b0;
            min_cnt_q <= 6'h0;
            {min_err_q, min_bits_q} <= 64'h0;
         end else if (tick[3]) begin
            ses_run_q <= ~ses_now ? 4'h0 : (ses_run_q == RUN_LAST) ? RUN_LAST : ses_run_q + 4'h1;
            ok_run_q <= ses_now ? 4'h0 : (ok_run_q == RUN_LAST) ? RUN_LAST : ok_run_q + 4'h1;
            unav_q <= sec_unav;
            if (min_end) begin
               min_cnt_q <= 6'h0;
               {min_err_q, min_bits_q} <= 64'h0;
            end else if (min_step) begin
               min_cnt_q <= min_cnt_q + 6'h1;
               min_err_q <= min_err_q + sec_err_q;
               min_bits_q <= min_bits_q + sec_bits_q;
            end
         end
      end
   end

   // Elapsed in the unit of the gating manner
   logic [31:0] elapsed;
   always_comb begin
      unique case (manner_q)
         MAN_ERRORS: elapsed = cnt_q[CNT_ERR];
         MAN_BITS: elapsed = cnt_q[CNT_CLK];
         default: elapsed = cnt_q[CNT_SECS];
      endcase
   end
   wire gate_reach = gate_act_q & (elapsed >= limit_q);
   // Nothing is counted at the edge where the limit closes the period
   assign cnt_en = gate_act_q & ~gate_reach;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         {gate_on_q, gate_act_q, gate_done_q, ran_q, prev_ok_q} <= 5'h0;
      end else begin
         gate_on_q <= gate_on;
         gate_done_q <= gate_reach;
         if (gate_start) begin
            gate_act_q <= 1'b1;
            ran_q <= 1'b1;
            // Previous results valid in repetitive timed gating only
            prev_ok_q <= ran_q & rep_q & (manner_q == MAN_TIME);
         end else if (gate_reach | ~gate_on) begin
            gate_act_q <= 1'b0;
         end
      end
   end

   // Configuration registers and error capture
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         {block_on_q, rep_q, prev_sel_q, capture_q} <= 4'h0;
         manner_q <= MAN_TIME;
         {sbit_pos_q, blk_start_q, blk_len_q, limit_q} <= 128'h0;
      end else begin
         if (wr_ctrl) begin
            block_on_q <= bus.wdata[CTRL_BLOCK];
            manner_q <= bem_manner_type'(bus.wdata[CTRL_MAN_HI:CTRL_MAN_LO]);
            rep_q <= bus.wdata[CTRL_REP];
            prev_sel_q <= bus.wdata[CTRL_PREV];
         end
         if (cap_fire) sbit_pos_q <= smp.pos;
         // Written value stands until a capture fires
         else if (wr_sbit) sbit_pos_q <= bus.wdata;
         if (cap_fire) capture_q <= 1'b0;
         else if (wr_ctrl & bus.wdata[CTRL_CAPTURE] & ~prbs_sel) capture_q <= 1'b1;
         if (wr_start) blk_start_q <= bus.wdata;
         if (wr_len) blk_len_q <= bus.wdata;
         if (wr_limit) limit_q <= bus.wdata;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         log_pend_q <= 1'b0;
         log_q <= 32'h0;
      end else if (log_valid & ~log_pend_q) begin
         log_pend_q <= 1'b1;
         log_q <= log_line;
      end else if (rd_log) begin
         log_pend_q <= 1'b0;
      end
   end

   // Shared serial divider cycles through all ratio slots
   bem_div_state_type div_st_q;
   logic [3:0] slot_q;
   logic [5:0] step_q;
   logic [32:0] rem_q;
   logic [31:0] den_q, quo_q;
   logic [31:0] num_w, den_w;
   always_comb begin
      num_w = 32'h0;
      den_w = 32'h0;
      unique case (slot_q)
         4'h0: begin num_w = cnt_q[CNT_ERR]; den_w = cnt_q[CNT_BITS]; end
         4'h1: begin num_w = delta_q[0]; den_w = delta_q[1]; end
         4'h2: begin num_w = cnt_q[CNT_ZASO]; den_w = cnt_q[CNT_BITS]; end
         4'h3: begin num_w = cnt_q[CNT_OASZ]; den_w = cnt_q[CNT_BITS]; end
         4'h4: begin num_w = cnt_q[CNT_SB_ERR]; den_w = cnt_q[CNT_SB_BITS]; end
         4'h5: begin num_w = delta_q[2]; den_w = delta_q[3]; end
         4'h6: begin num_w = cnt_q[CNT_AVAIL]; den_w = cnt_q[CNT_SECS]; end
         4'h7: begin num_w = cnt_q[CNT_UNAV]; den_w = cnt_q[CNT_SECS]; end
         4'h8: begin num_w = cnt_q[CNT_SES]; den_w = cnt_q[CNT_AVAIL]; end
         4'h9: begin num_w = cnt_q[CNT_DM]; den_w = cnt_q[CNT_MIN]; end
         4'ha: begin num_w = cnt_q[CNT_ES_BASE+3]; den_w = cnt_q[CNT_SECS]; end
         default: ;
      endcase
   end
   wire [32:0] rem_sh = {rem_q[31:0], 1'b0};
   wire rem_ge = rem_sh >= {1'b0, den_q};
   wire [3:0] slot_nx = (slot_q == RATIO_LAST) ? 4'h0 : slot_q + 4'h1;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         div_st_q <= DIV_LOAD;
         {slot_q, step_q} <= 10'h0;
         {rem_q, den_q, quo_q} <= 97'h0;
         rnan_q <= '1;
         for (int i = 0; i < NUM_RATIO; i++) ratio_q[i] <= 32'h0;
      end else begin
         unique case (div_st_q)
            DIV_LOAD: begin
               rem_q <= {1'b0, num_w};
               den_q <= den_w;
               step_q <= 6'h0;
               quo_q <= 32'h0;
               if (den_w == 32'h0) begin
                  rnan_q[slot_q] <= 1'b1;
                  slot_q <= slot_nx;
               end else if (num_w >= den_w) begin
                  // Ratio of one or more saturates to full scale
                  rnan_q[slot_q] <= 1'b0;
                  ratio_q[slot_q] <= 32'hffff_ffff;
                  slot_q <= slot_nx;
               end else begin
                  div_st_q <= DIV_RUN;
               end
            end
            DIV_RUN: begin
               rem_q <= rem_ge ? rem_sh - {1'b0, den_q} : rem_sh;
               quo_q <= {quo_q[30:0], rem_ge};
               step_q <= step_q + 6'h1;
               if (step_q == 6'h1f) begin
                  ratio_q[slot_q] <= {quo_q[30:0], rem_ge};
                  rnan_q[slot_q] <= 1'b0;
                  slot_q <= slot_nx;
                  div_st_q <= DIV_LOAD;
               end
            end
         endcase
      end
   end

   // Read decode
   wire [4:0] ridx = bus.addr[6:2];
   wire in_cnt = (bus.addr[9:7] == OFF_CNT_BASE[9:7]) & (ridx < 5'(NUM_CNT));
   wire in_delta = (bus.addr[9:6] == OFF_DELTA_BASE[9:6]) & (ridx < 5'(NUM_DELTA));
   wire [3:0] rsel = bus.addr[5:2];
   wire in_ratio = (bus.addr[9:6] == OFF_RATIO_BASE[9:6]) & (rsel < 4'(NUM_RATIO));
   wire [31:0] cnt_sel = prev_sel_q ? prev_q[ridx] : cnt_q[ridx];
   // Sentinel for results that cannot be given
   wire cnt_nan = (prev_sel_q & ~prev_ok_q) | (~pwr_meas_ok & (ridx == 5'(CNT_PWR)))
                | (prbs_sel & ((ridx == 5'(CNT_SB_ERR)) | (ridx == 5'(CNT_SB_BITS))));
   wire delta_nan = prbs_sel & ridx[1];
   wire ratio_nan = rnan_q[rsel] | (prbs_sel & ((rsel == 4'h4) | (rsel == 4'h5)));
   wire [7:0] ctrl_rd = {gate_act_q, prev_ok_q, prev_sel_q, rep_q, manner_q, capture_q,
                         block_on_q};
   wire [31:0] rd_mux =
      (bus.addr == OFF_CTRL) ? {24'h0, ctrl_rd} :
      (bus.addr == OFF_SBIT_POS) ? sbit_pos_q :
      (bus.addr == OFF_BLK_START) ? blk_start_q :
      (bus.addr == OFF_BLK_LEN) ? blk_len_q :
      (bus.addr == OFF_GATE_LIMIT) ? limit_q :
      (bus.addr == OFF_LOG) ? (log_pend_q ? log_q : NO_TEXT_WORD) :
      (bus.addr == OFF_FREQ) ? freq_q :
      (bus.addr == OFF_ELAPSED) ? elapsed :
      in_cnt ? (cnt_nan ? NAN_WORD : cnt_sel) :
      in_delta ? (delta_nan ? NAN_WORD : delta_q[ridx[1:0]]) :
      in_ratio ? (ratio_nan ? NAN_WORD : ratio_q[rsel]) : 32'h0;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) rdata_q <= 32'h0;
      else if (bus.rd) rdata_q <= rd_mux;
   end

   assign rdata = rdata_q;
   assign log_ready = ~log_pend_q;
   assign gate_done = gate_done_q;
   assign gate_active = gate_act_q;
   assign capture_busy = capture_q;
endmodule : bem_counters

/* verification/bem_asserts.sv */
// Port-level checks of the bit-error measurement core
`timescale 1ns/100ps
module bem_asserts
   import bem_pkg::*;
(
   input wire logic mclk, // Clock
   input wire logic sys_rst, // Reset
   input wire bem_bus_req_type bus, // Register request
   input wire bem_sample_type smp, // Data sample
   input wire logic prbs_sel, // Pure PRBS
   input wire logic gate_on, // Gating request
   input wire logic log_valid, // Line offered
   input wire logic log_ready, // Holder empty
   input wire logic gate_done, // Limit pulse
   input wire logic gate_active, // Period running
   input wire logic capture_busy // Capture armed
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence s_arm;
      bus.wr && bus.addr == OFF_CTRL && bus.wdata[CTRL_CAPTURE];
   endsequence
   sequence s_err;
      capture_busy && smp.valid && smp.rx != smp.ref_bit && !prbs_sel;
   endsequence
   property p_start; $rose(gate_on) |=> gate_active; endproperty
   a_start: assert property (p_start) else $error("gating did not start");
   property p_stop; !gate_on |=> !gate_active; endproperty
   a_stop: assert property (p_stop) else $error("gating kept running");
   property p_end; gate_done |-> !gate_active && $past(gate_active); endproperty
   a_end: assert property (p_end) else $error("limit pulse without period end");
   property p_pulse; gate_done |=> !gate_done; endproperty
   a_pulse: assert property (p_pulse) else $error("limit pulse too long");
   property p_arm; s_arm ##0 !prbs_sel |=> capture_busy; endproperty
   a_arm: assert property (p_arm) else $error("capture not armed");
   property p_arm_prbs; s_arm ##0 (prbs_sel && !capture_busy) |=> !capture_busy; endproperty
   a_arm_prbs: assert property (p_arm_prbs) else $error("capture armed on PRBS");
   property p_fire; s_err |=> !capture_busy; endproperty
   a_fire: assert property (p_fire) else $error("capture did not fire");
   property p_log_take; log_valid && log_ready |=> !log_ready; endproperty
   a_log_take: assert property (p_log_take) else $error("log line not held");
   property p_log_read; bus.rd && bus.addr == OFF_LOG && !log_ready |=> log_ready; endproperty
   a_log_read: assert property (p_log_read) else $error("log read kept line");
endmodule : bem_asserts
bind bem_counters bem_asserts u_bem_asserts (.mclk(mclk), .sys_rst(sys_rst), .bus(bus),
   .smp(smp), .prbs_sel(prbs_sel), .gate_on(gate_on), .log_valid(log_valid),
   .log_ready(log_ready), .gate_done(gate_done), .gate_active(gate_active),
   .capture_busy(capture_busy));

/* verification/bem_stream_model.sv */
// Data source and log producer on the far side of the measurement core
`timescale 1ns/100ps
module bem_stream_model
   import bem_pkg::*;
#(
   parameter int PLEN = 64,
   parameter logic [31:0] LINE = 32'h0000_00a5
) (
   input wire logic mclk, // Clock
   input wire logic sys_rst, // Reset
   input wire logic run, // Stream bits while high
   input wire logic [31:0] err_pos, // Position received inverted
   input wire logic log_req, // Offer one log line
   input wire logic log_ready, // Holder empty
   output bem_sample_type smp, // Sample to the core
   output logic log_valid, // Line offered
   output logic [31:0] log_line // Line word
);
   logic [31:0] pos_q;
   logic ref_w;
   // Position restarts while idle so every burst begins at bit 0
   always_ff @(posedge mclk) begin
      pos_q <= (!run || pos_q == PLEN - 1) ? 32'h0 : pos_q + 32'h1;
   end
   assign ref_w = pos_q[0] ^ pos_q[3];
   assign smp = '{valid: run, rx: ref_w ^ (pos_q == err_pos), ref_bit: ref_w, pos: pos_q};
   // Line held until taken; idle word is inverted so stale data never matches
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         log_valid <= 1'b0;
      end else if (log_valid && log_ready) begin
         log_valid <= 1'b0;
      end else if (log_req) begin
         log_valid <= 1'b1;
      end
   end
   assign log_line = log_valid ? LINE : ~LINE;
endmodule : bem_stream_model

/* verification/tb_top.sv */
// Self-checking bench for the bit-error measurement core
`timescale 1ns/100ps
module tb_top;
   import bem_pkg::*;
   localparam logic [31:0] LINE = 32'h0000_00a5;
   logic mclk, sys_rst, prbs_sel, pwr_meas_ok, gate_on, run, log_req, log_valid, log_ready;
   logic gate_done, gate_active, capture_busy;
   logic pwr_fail, sync_lost;
   logic [31:0] rdata, log_line;
   bem_bus_req_type bus;
   bem_sample_type smp;
   int miscompares = 0;
   int comparisons = 0;
   int n;
   int exp1[8] = '{2, 128, 2, 0, 2, 2, 2, 1};
   int exp2[4] = '{2, 128, 2, 2};
   bem_counters #(.MS_CYC(10)) u_bem_counters (.mclk(mclk), .sys_rst(sys_rst), .bus(bus),
      .rdata(rdata), .smp(smp), .pattern_len(32'd64), .prbs_sel(prbs_sel), .sync_lost(sync_lost),
      .pwr_fail_pin(pwr_fail), .pwr_meas_ok(pwr_meas_ok), .gate_on(gate_on),
      .log_valid(log_valid), .log_line(log_line), .log_ready(log_ready),
      .gate_done(gate_done), .gate_active(gate_active), .capture_busy(capture_busy));
   bem_stream_model #(.LINE(LINE)) u_bem_stream_model (.mclk(mclk), .sys_rst(sys_rst),
      .run(run), .err_pos(32'd9), .log_req(log_req), .log_ready(log_ready), .smp(smp),
      .log_valid(log_valid), .log_line(log_line));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic final_report;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Each access ends idle one edge later, so no signal is driven twice in a step
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus <= '0;
      @(posedge mclk);
   endtask : wr
   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus <= '0;
      @(posedge mclk);
      chk(rdata, e);
   endtask : rd
   function automatic logic [9:0] ca(input int i);
      return OFF_CNT_BASE + 10'(4 * i);
   endfunction : ca
   task automatic stream(input int k);
      run <= 1'b1;
      repeat (k) @(posedge mclk);
      run <= 1'b0;
      @(posedge mclk);
   endtask : stream
   task automatic gate(input logic [31:0] c);
      gate_on <= 1'b0;
      @(posedge mclk);
      wr(OFF_CTRL, c);
      gate_on <= 1'b1;
      repeat (2) @(posedge mclk);
   endtask : gate
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      final_report();
   end
   initial begin
      sys_rst = 1'b1;
      bus = '0;
      {prbs_sel, gate_on, run, log_req, pwr_fail, sync_lost} = 6'h0;
      pwr_meas_ok = 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      rd(10'h3fc, 32'h0);
      rd(OFF_LOG, NO_TEXT_WORD);
      log_req <= 1'b1;
      @(posedge mclk);
      log_req <= 1'b0;
      repeat (3) @(posedge mclk);
      rd(OFF_LOG, LINE);
      rd(OFF_LOG, NO_TEXT_WORD);
      wr(OFF_SBIT_POS, 32'h5);
      rd(OFF_SBIT_POS, 32'h5);
      wr(OFF_CTRL, 32'h2);
      stream(64);
      rd(OFF_SBIT_POS, 32'h9);
      wr(OFF_GATE_LIMIT, 32'd100);
      gate(32'h0);
      stream(128);
      repeat (400) @(posedge mclk);
      for (int i = 0; i < 8; i++) rd(ca(i), exp1[i]);
      rd(OFF_RATIO_BASE, 32'h0400_0000);
      rd(OFF_RATIO_BASE + 10'h8, 32'h0400_0000);
      // Past the first decisecond boundary and one full divider round
      repeat (900) @(posedge mclk);
      for (int i = 0; i < 4; i++) rd(OFF_DELTA_BASE + 10'(4 * i), exp2[i]);
      rd(OFF_RATIO_BASE + 10'h4, 32'h0400_0000);
      rd(OFF_RATIO_BASE + 10'h10, 32'hffff_ffff);
      wr(OFF_BLK_START, 32'd48);
      wr(OFF_BLK_LEN, 32'd32);
      gate(32'h1);
      wr(OFF_CTRL, 32'h21);
      rd(ca(CNT_ERR), NAN_WORD);
      wr(OFF_CTRL, 32'h11);
      stream(128);
      rd(ca(CNT_ERR), 32'd2);
      rd(ca(CNT_BITS), 32'd64);
      rd(ca(CNT_CLK), 32'd128);
      wr(OFF_GATE_LIMIT, 32'd1);
      gate(32'h10);
      wr(OFF_CTRL, 32'h30);
      rd(ca(CNT_ERR), 32'd2);
      wr(OFF_CTRL, 32'h10);
      {sync_lost, pwr_fail} <= 2'h3;
      repeat (20) @(posedge mclk);
      {sync_lost, pwr_fail} <= 2'h0;
      for (n = 0; n < 12000 && gate_done !== 1'b1; n++) @(posedge mclk);
      chk(32'(n < 12000), 32'h1);
      rd(OFF_ELAPSED, 32'd1);
      for (int i = 0; i < 4; i++) rd(ca(CNT_EF_BASE + i), 32'(1000 / (10 ** i)));
      rd(ca(CNT_ES_BASE + 3), 32'h0);
      rd(ca(CNT_PWR), 32'h1);
      rd(ca(CNT_SYNC), 32'h1);
      rd(ca(CNT_AVAIL), 32'h1);
      wr(OFF_GATE_LIMIT, 32'd50);
      gate(32'h8);
      stream(64);
      rd(OFF_ELAPSED, 32'd50);
      wr(OFF_GATE_LIMIT, 32'd1);
      gate(32'h4);
      stream(64);
      rd(OFF_ELAPSED, 32'd1);
      prbs_sel <= 1'b1;
      pwr_meas_ok <= 1'b0;
      wr(OFF_CTRL, 32'h2);
      chk({31'h0, capture_busy}, 32'h0);
      rd(ca(CNT_SB_ERR), NAN_WORD);
      rd(ca(CNT_PWR), NAN_WORD);
      final_report();
   end
endmodule : tb_top
